// [src/cmcr_defs.svh]
// Notes on behaviour
// - handler mode only at privileged level
// - user level blocks restricted access, faults
// - privileged level allows restricted access
// - handler while servicing exception, else thread
// - sixteen core registers, each 32 bits
// - low registers reachable by short and long encodings
// - high registers: long always, short sometimes
// - register thirteen banks main and process stacks
// - process stack only in user thread
// - stack pointer low two bits read zero
// - subroutine call writes return address to link
// - only mixed 16/32-bit set; legacy faults
// - bit-band aliasing for the SRAM region
// - unaligned data accesses are supported
// - program counter bit zero reads zero
// - control bit zero: one means user thread
// - control bit one selects process stack
`ifndef CMCR_DEFS_SVH
`define CMCR_DEFS_SVH
`define CMCR_XLEN            32
`define CMCR_NREG            16
`define CMCR_IDX_SP          4'hd
`define CMCR_IDX_LINK        4'he
`define CMCR_IDX_PC          4'hf
`define CMCR_NUM_LOW         8
`define CMCR_CTRL_USER_BIT   0
`define CMCR_CTRL_PSTK_BIT   1
`define CMCR_SP_MASK         32'hffff_fffc
`define CMCR_PC_MASK         32'hffff_fffe
`define CMCR_RST_CTRL        2'h0
`define CMCR_SRAM_BASE       32'h2000_0000
`define CMCR_SRAM_ALIAS_BASE 32'h2200_0000
`define CMCR_SRAM_ALIAS_TOP  32'h23ff_ffff
`endif

// [src/cmcr_pkg.sv]
`include "cmcr_defs.svh"
package cmcr_pkg;
  typedef logic [`CMCR_XLEN-1:0] cmcr_word_t;
  typedef logic [3:0]            cmcr_idx_t;
  typedef enum logic [2:0] {
    CMCR_PRIV_THREAD = 3'b001,
    CMCR_USER_THREAD = 3'b010,
    CMCR_PRIV_HANDLER = 3'b100
  } cmcr_state_t;
  typedef enum logic [1:0] {
    CMCR_ISA_SHORT  = 2'h0,
    CMCR_ISA_LONG   = 2'h1,
    CMCR_ISA_LEGACY = 2'h2
  } cmcr_isa_t;
endpackage : cmcr_pkg

// [src/cmcr_bitband.sv]
`include "cmcr_defs.svh"
module cmcr_bitband (
  input  wire logic [31:0] addr,
  output logic             alias_hit,
  output logic [31:0]      word_addr,
  output logic [4:0]       bit_pos
);
  wire logic [31:0] offset;
  assign alias_hit = (addr >= `CMCR_SRAM_ALIAS_BASE) && (addr <= `CMCR_SRAM_ALIAS_TOP);
  assign offset    = addr - `CMCR_SRAM_ALIAS_BASE;
  assign word_addr = `CMCR_SRAM_BASE + {12'h000, offset[24:7], 2'h0};
  assign bit_pos   = offset[6:2];
endmodule : cmcr_bitband

// [src/cmcr_core.sv]
`include "cmcr_defs.svh"
module cmcr_core #(
  parameter int XLEN = `CMCR_XLEN
) (
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                exc_enter,
  input  wire logic                exc_return,
  input  wire logic                access_req,
  input  wire logic                access_restricted,
  input  wire cmcr_pkg::cmcr_isa_t isa_kind,
  input  wire logic                short_high_ok,
  input  wire cmcr_pkg::cmcr_idx_t rd_idx,
  input  wire cmcr_pkg::cmcr_idx_t wr_idx,
  input  wire logic                wr_en,
  input  wire cmcr_pkg::cmcr_word_t wr_data,
  input  wire logic                call_en,
  input  wire cmcr_pkg::cmcr_word_t call_return_addr,
  input  wire logic                pc_load,
  input  wire cmcr_pkg::cmcr_word_t pc_value,
  input  wire logic                ctrl_wr,
  input  wire logic [1:0]          ctrl_data,
  input  wire cmcr_pkg::cmcr_word_t data_addr,
  output logic                     access_fault,
  output logic                     handler_mode,
  output logic                     user_level,
  output logic [1:0]               ctrl_out,
  output cmcr_pkg::cmcr_word_t     rd_data,
  output cmcr_pkg::cmcr_word_t     stack_pointer_reg,
  output cmcr_pkg::cmcr_word_t     program_counter,
  output cmcr_pkg::cmcr_word_t     return_link_register,
  output logic                     bitband_hit,
  output cmcr_pkg::cmcr_word_t     bitband_word_addr,
  output logic [4:0]               bitband_bit,
  output logic [1:0]               data_byte_lane
);
  import cmcr_pkg::*;

  if (XLEN != 32) begin : g_bad_xlen
    $error("cmcr_core supports only a 32-bit word");
  end

  cmcr_state_t state_reg;
  cmcr_state_t state_next;
  logic [1:0]  ctrl_reg;
  logic [1:0]  ctrl_next;
  cmcr_word_t  gpr_reg [0:12];
  cmcr_word_t  main_stack_pointer;
  cmcr_word_t  process_stack_pointer;
  cmcr_word_t  link_register_slot;
  cmcr_word_t  pc_reg;
  logic        fault_reg;
  cmcr_word_t  rd_reg;
  logic        bb_hit_reg;
  cmcr_word_t  bb_addr_reg;
  logic [4:0]  bb_bit_reg;
  logic [1:0]  lane_reg;

  wire logic       in_handler;
  wire logic       in_user;
  wire logic       use_psp;
  wire cmcr_word_t sp_active;
  wire logic       legacy_fault;
  wire logic       priv_fault;
  wire logic       high_fault;
  wire logic       idx_high;
  wire logic       ctrl_wr_ok;
  wire logic       fault_now;
  wire logic       wr_ok;
  wire cmcr_word_t rd_sel;
  wire logic       bb_hit_w;
  wire cmcr_word_t bb_addr_w;
  wire logic [4:0] bb_bit_w;

  assign in_handler   = (state_reg == CMCR_PRIV_HANDLER);
  assign in_user      = (state_reg == CMCR_USER_THREAD);
  assign use_psp      = ctrl_reg[`CMCR_CTRL_PSTK_BIT] && in_user;
  assign sp_active    = (use_psp ? process_stack_pointer : main_stack_pointer) & `CMCR_SP_MASK;
  assign legacy_fault = access_req && (isa_kind == CMCR_ISA_LEGACY);
  assign priv_fault   = access_req && in_user && access_restricted;
  assign idx_high     = (wr_idx >= 4'(`CMCR_NUM_LOW)) && (wr_idx < `CMCR_IDX_SP);
  assign high_fault   = access_req && wr_en && idx_high && (isa_kind == CMCR_ISA_SHORT) && !short_high_ok;
  assign fault_now    = legacy_fault || priv_fault || high_fault;
  assign ctrl_wr_ok   = ctrl_wr && !in_user && !fault_now;
  assign wr_ok        = wr_en && !fault_now;

  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrl_wr_ok) begin
      ctrl_next = ctrl_data;
    end
    if (in_handler || exc_enter) begin
      ctrl_next[`CMCR_CTRL_PSTK_BIT] = 1'b0;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CMCR_PRIV_THREAD: begin
        if (exc_enter) begin
          state_next = CMCR_PRIV_HANDLER;
        end else if (ctrl_next[`CMCR_CTRL_USER_BIT]) begin
          state_next = CMCR_USER_THREAD;
        end
      end
      CMCR_USER_THREAD: begin
        if (exc_enter) begin
          state_next = CMCR_PRIV_HANDLER;
        end
      end
      CMCR_PRIV_HANDLER: begin
        if (exc_return && !exc_enter) begin
          state_next = ctrl_reg[`CMCR_CTRL_USER_BIT] ? CMCR_USER_THREAD : CMCR_PRIV_THREAD;
        end
      end
      default: state_next = CMCR_PRIV_THREAD;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= CMCR_PRIV_THREAD;
      ctrl_reg  <= `CMCR_RST_CTRL;
    end else begin
      state_reg <= state_next;
      ctrl_reg  <= ctrl_next;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 13; gi++) begin : g_gpr
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          gpr_reg[gi] <= '0;
        end else if (wr_ok && wr_idx == 4'(gi)) begin
          gpr_reg[gi] <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      main_stack_pointer    <= '0;
      process_stack_pointer <= '0;
    end else if (wr_ok && wr_idx == `CMCR_IDX_SP) begin
      if (use_psp) begin
        process_stack_pointer <= wr_data & `CMCR_SP_MASK;
      end else begin
        main_stack_pointer <= wr_data & `CMCR_SP_MASK;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link_register_slot <= '0;
    end else if (call_en && !fault_now) begin
      link_register_slot <= call_return_addr;
    end else if (wr_ok && wr_idx == `CMCR_IDX_LINK) begin
      link_register_slot <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg <= '0;
    end else if (pc_load) begin
      pc_reg <= pc_value & `CMCR_PC_MASK;
    end else if (wr_ok && wr_idx == `CMCR_IDX_PC) begin
      pc_reg <= wr_data & `CMCR_PC_MASK;
    end
  end

  assign rd_sel = (rd_idx == `CMCR_IDX_SP)   ? sp_active :
                  (rd_idx == `CMCR_IDX_LINK) ? link_register_slot :
                  (rd_idx == `CMCR_IDX_PC)   ? pc_reg :
                  gpr_reg[rd_idx];

  cmcr_bitband u_bitband (
    .addr      (data_addr),
    .alias_hit (bb_hit_w),
    .word_addr (bb_addr_w),
    .bit_pos   (bb_bit_w)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fault_reg   <= 1'b0;
      rd_reg      <= '0;
      bb_hit_reg  <= 1'b0;
      bb_addr_reg <= '0;
      bb_bit_reg  <= '0;
      lane_reg    <= '0;
    end else begin
      fault_reg   <= fault_now;
      rd_reg      <= rd_sel;
      bb_hit_reg  <= bb_hit_w;
      bb_addr_reg <= bb_addr_w;
      bb_bit_reg  <= bb_bit_w;
      lane_reg    <= data_addr[1:0];
    end
  end

  assign access_fault         = fault_reg;
  assign handler_mode         = state_reg[2];
  assign user_level           = state_reg[1];
  assign ctrl_out             = ctrl_reg;
  assign rd_data              = rd_reg;
  assign stack_pointer_reg    = sp_active;
  assign program_counter      = pc_reg;
  assign return_link_register = link_register_slot;
  assign bitband_hit          = bb_hit_reg;
  assign bitband_word_addr    = bb_addr_reg;
  assign bitband_bit          = bb_bit_reg;
  assign data_byte_lane       = lane_reg;
endmodule : cmcr_core

// [bench/cmcr_core_assertions.sv]
module cmcr_chk (
  input wire logic                 clk_sys,
  input wire logic                 rst_n,
  input wire logic                 exc_enter,
  input wire logic                 exc_return,
  input wire logic                 access_req,
  input wire logic                 access_restricted,
  input wire cmcr_pkg::cmcr_isa_t  isa_kind,
  input wire logic                 call_en,
  input wire cmcr_pkg::cmcr_word_t call_return_addr,
  input wire logic                 pc_load,
  input wire cmcr_pkg::cmcr_word_t pc_value,
  input wire cmcr_pkg::cmcr_word_t data_addr,
  input wire logic                 access_fault,
  input wire logic                 handler_mode,
  input wire logic                 user_level,
  input wire logic [1:0]           ctrl_out,
  input wire cmcr_pkg::cmcr_word_t stack_pointer_reg,
  input wire cmcr_pkg::cmcr_word_t program_counter,
  input wire cmcr_pkg::cmcr_word_t return_link_register,
  input wire logic                 bitband_hit
);
  timeunit 1ns;
  timeprecision 1ns;
  import cmcr_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_enter; exc_enter; endsequence
  sequence s_leave; exc_return && !exc_enter; endsequence
  chk_no_user_handler: assert property (!(handler_mode && user_level))
    else $error("handler mode at user level");
  chk_user_block: assert property (access_req && access_restricted && user_level |=> access_fault)
    else $error("user access not refused");
  chk_priv_allow: assert property (access_req && !user_level && isa_kind == CMCR_ISA_LONG |=> !access_fault)
    else $error("privileged access refused");
  chk_enter_mode: assert property (s_enter |=> handler_mode && !user_level && !ctrl_out[1])
    else $error("entry state wrong");
  chk_leave_mode: assert property (s_enter ##1 s_leave |=> !handler_mode && user_level == ctrl_out[0])
    else $error("return state wrong");
  chk_sp_aligned: assert property (stack_pointer_reg[1:0] == 2'h0)
    else $error("stack pointer unaligned");
  chk_link_write: assert property (call_en && !access_req |=> return_link_register == $past(call_return_addr))
    else $error("link not written");
  chk_pc_even: assert property (pc_load |=> program_counter == ($past(pc_value) & 32'hffff_fffe))
    else $error("program counter load wrong");
  chk_legacy_fault: assert property (access_req && isa_kind == CMCR_ISA_LEGACY |=> access_fault)
    else $error("legacy encoding accepted");
  chk_alias_hit: assert property (data_addr[31:25] == 7'h11 |=> bitband_hit)
    else $error("alias address missed");
endmodule : cmcr_chk

bind cmcr_core cmcr_chk u_chk (.clk_sys, .rst_n, .exc_enter, .exc_return, .access_req, .access_restricted,
  .isa_kind, .call_en, .call_return_addr, .pc_load, .pc_value, .data_addr, .access_fault, .handler_mode,
  .user_level, .ctrl_out, .stack_pointer_reg, .program_counter, .return_link_register, .bitband_hit);

// [bench/cmcr_bus_model.sv]
module cmcr_bus_model (
  input  wire logic           clk_sys,
  input  wire logic [1:0]     pick,
  output cmcr_pkg::cmcr_word_t data_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  import cmcr_pkg::*;
  initial data_addr = 32'h0;
  // data side address: unaligned bytes in and out of the alias region
  always @(posedge clk_sys) begin
    case (pick)
      2'h1: data_addr <= 32'h2200_00a7;
      2'h2: data_addr <= 32'h2000_0002;
      default: data_addr <= 32'h0;
    endcase
  end
endmodule : cmcr_bus_model

// [bench/cmcr_core_test.sv]
module cmcr_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cmcr_pkg::*;
  typedef struct {cmcr_isa_t isa; logic hok; cmcr_idx_t idx; cmcr_word_t dat; cmcr_word_t exp; logic flt;} cmcr_row_t;
  logic       clk_sys = 1'b0, rst_n = 1'b0, exc_enter = 1'b0, exc_return = 1'b0, access_req = 1'b0;
  logic       access_restricted = 1'b0, short_high_ok = 1'b0, wr_en = 1'b0, call_en = 1'b0;
  logic       pc_load = 1'b0, ctrl_wr = 1'b0, access_fault, handler_mode, user_level, bitband_hit;
  cmcr_isa_t  isa_kind = CMCR_ISA_LONG;
  cmcr_idx_t  rd_idx = 4'h0, wr_idx = 4'h0;
  cmcr_word_t wr_data = 32'h0, call_return_addr = 32'h0, pc_value = 32'h0;
  cmcr_word_t data_addr, rd_data, stack_pointer_reg, program_counter, return_link_register;
  logic [1:0] ctrl_data = 2'h0, pick = 2'h0, ctrl_out, data_byte_lane;
  cmcr_word_t bitband_word_addr;
  logic [4:0] bitband_bit;
  int         err_total = 0;
  int         check_count = 0;
  cmcr_row_t  rows [6] = '{
    '{CMCR_ISA_SHORT, 1'b0, 4'h0, 32'h1111_1111, 32'h1111_1111, 1'b0},
    '{CMCR_ISA_LONG, 1'b0, 4'h8, 32'h8888_8888, 32'h8888_8888, 1'b0},
    '{CMCR_ISA_SHORT, 1'b1, 4'hc, 32'hcccc_cccc, 32'hcccc_cccc, 1'b0},
    '{CMCR_ISA_SHORT, 1'b0, 4'h8, 32'hdead_0000, 32'h8888_8888, 1'b1},
    '{CMCR_ISA_LEGACY, 1'b0, 4'h0, 32'hdead_0001, 32'h1111_1111, 1'b1},
    '{CMCR_ISA_LONG, 1'b0, 4'hd, 32'h1234_5677, 32'h1234_5674, 1'b0}};
  cmcr_core u_dut (.clk_sys, .rst_n, .exc_enter, .exc_return, .access_req, .access_restricted, .isa_kind,
    .short_high_ok, .rd_idx, .wr_idx, .wr_en, .wr_data, .call_en, .call_return_addr, .pc_load, .pc_value,
    .ctrl_wr, .ctrl_data, .data_addr, .access_fault, .handler_mode, .user_level, .ctrl_out, .rd_data,
    .stack_pointer_reg, .program_counter, .return_link_register, .bitband_hit, .bitband_word_addr,
    .bitband_bit, .data_byte_lane);
  cmcr_bus_model u_bus (.clk_sys, .pick, .data_addr);
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(input cmcr_word_t got, input cmcr_word_t exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  // one-cycle strobes: enter, return, access, write, call, pc, ctrl
  task automatic fire(input logic [6:0] s);
    @(posedge clk_sys);
    {exc_enter, exc_return, access_req, wr_en, call_en, pc_load, ctrl_wr} <= s;
    @(posedge clk_sys);
    {exc_enter, exc_return, access_req, wr_en, call_en, pc_load, ctrl_wr} <= 7'h0;
    #1;
  endtask : fire
  initial begin
    #200000;
    err_total++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    #1 check({27'h0, handler_mode, user_level, ctrl_out, access_fault}, 32'h0);
    check(stack_pointer_reg, 32'h0);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      isa_kind <= rows[i].isa;
      short_high_ok <= rows[i].hok;
      wr_idx <= rows[i].idx;
      rd_idx <= rows[i].idx;
      wr_data <= rows[i].dat;
      fire(7'h18);
      check({31'h0, access_fault}, {31'h0, rows[i].flt});
      @(posedge clk_sys);
      #1 check(rd_data, rows[i].exp);
    end
    isa_kind <= CMCR_ISA_LONG;
    access_restricted <= 1'b1;
    fire(7'h10);
    check({31'h0, access_fault}, 32'h0);
    call_return_addr <= 32'h0000_0101;
    pc_value <= 32'h0000_0203;
    pick <= 2'h1;
    fire(7'h06);
    check(return_link_register, 32'h0000_0101);
    check(program_counter, 32'h0000_0202);
    check({29'h0, bitband_hit, data_byte_lane}, 32'h7);
    check(bitband_word_addr, 32'h2000_0004);
    check({27'h0, bitband_bit}, 32'h9);
    pick <= 2'h2;
    repeat (2) @(posedge clk_sys);
    #1 check({29'h0, bitband_hit, data_byte_lane}, 32'h2);
    ctrl_data <= 2'h3;
    fire(7'h01);
    @(posedge clk_sys);
    #1 check({28'h0, handler_mode, user_level, ctrl_out}, 32'h7);
    ctrl_data <= 2'h0;
    fire(7'h11);
    check({31'h0, access_fault}, 32'h1);
    access_restricted <= 1'b0;
    wr_idx <= 4'hd;
    wr_data <= 32'h0000_aaab;
    fire(7'h18);
    check({28'h0, handler_mode, user_level, ctrl_out}, 32'h7);
    check(stack_pointer_reg, 32'h0000_aaa8);
    @(posedge clk_sys);
    exc_enter <= 1'b1;
    @(posedge clk_sys);
    exc_enter <= 1'b0;
    exc_return <= 1'b1;
    #1 check({28'h0, handler_mode, user_level, ctrl_out}, 32'h9);
    check(stack_pointer_reg, 32'h1234_5674);
    @(posedge clk_sys);
    exc_return <= 1'b0;
    #1 check({30'h0, handler_mode, user_level}, 32'h1);
    conclude();
  end
endmodule : cmcr_core_test
